// >>> core/sfp_pkg.sv
// Constants for the serial flash sleep and pause control block
package sfp_pkg;
  // Opcodes
  localparam logic [7:0] SFP_OP_SLEEP = 8'hB9;
  localparam logic [7:0] SFP_OP_WAKE  = 8'hAB;
  localparam logic [2:0] SFP_BIT_CNT_RST = 3'h0;
  // Timing, figures in ns
  localparam int SFP_CLK_PERIOD_NS       = 40;
  localparam int SFP_SLEEP_ENTRY_TIME_NS = 3000;
  localparam int SFP_SLEEP_EXIT_TIME_NS  = 8000;
  // Longest times round down, never below one cycle
  localparam int SFP_SLEEP_ENTRY_CYC_I = SFP_SLEEP_ENTRY_TIME_NS / SFP_CLK_PERIOD_NS;
  localparam int SFP_SLEEP_EXIT_CYC_I  = SFP_SLEEP_EXIT_TIME_NS / SFP_CLK_PERIOD_NS;
  localparam logic [11:0] SFP_SLEEP_ENTRY_CYC =
    12'((SFP_SLEEP_ENTRY_CYC_I < 1) ? 1 : SFP_SLEEP_ENTRY_CYC_I);
  localparam logic [11:0] SFP_SLEEP_EXIT_CYC =
    12'((SFP_SLEEP_EXIT_CYC_I < 1) ? 1 : SFP_SLEEP_EXIT_CYC_I);
  localparam logic [11:0] SFP_CNT_ZERO = 12'h000;
  // Two sync stages, the edge detect and the loading edge come off each budget,
  // so that the limit holds as seen from the pins
  localparam int SFP_PIN_LAT_CYC = 4;
  localparam logic [11:0] SFP_SLEEP_ENTRY_LOAD =
    12'((SFP_SLEEP_ENTRY_CYC_I > SFP_PIN_LAT_CYC) ?
        (SFP_SLEEP_ENTRY_CYC_I - SFP_PIN_LAT_CYC) : 0);
  localparam logic [11:0] SFP_SLEEP_EXIT_LOAD =
    12'((SFP_SLEEP_EXIT_CYC_I > SFP_PIN_LAT_CYC) ?
        (SFP_SLEEP_EXIT_CYC_I - SFP_PIN_LAT_CYC) : 0);
  // Power state
  typedef enum logic [1:0] {SFP_STANDBY, SFP_ENTERING, SFP_SLEEP, SFP_WAKING} sfp_pwr_t;
endpackage

// >>> core/sfp_power_hold.sv
// Sleep, wake and pause control of a serial flash command interface
// ----------------------------------------------------------------
// How it works
// - Sleep opcode B9h then deselect enters sleep; trailing bits are ignored.
// - While asleep every command except wake is ignored, so no program or erase.
// - Short sleep opcode or deselect off a byte boundary stays in standby.
// - Sleep is reached within the sleep entry time after deselect.
// - After reset the device is in standby.
// - Sleep request ignored during self-timed work; host must reissue later.
// - Wake opcode ABh wakes; bits after the opcode are discarded.
// - After wake, standby within the exit time after deselect; commands accepted.
// - Short wake opcode or deselect off a byte boundary stays asleep.
// - Standby whenever in the standby power state, deselected and no self-timed work runs.
// - Pause never stops self-timed program or erase.
// - Pause entered only while selected, sampled during clock low.
// - Pause asserted during clock high takes effect at next low phase.
// - Pause holds while both pause pin and select stay asserted.
// - Paused: output floats, input and clock ignored; write protect works.
// - Pause release is seen in clock low, else at next low phase.
// - Deselect while paused aborts the command and clears write enable latch.
// - Output launched on falling clock, input sampled on rising clock.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module sfp_power_hold
(
  // Clock, reset, enable
  input  wire logic     sys_clk,
  input  wire logic     rst,
  input  wire logic     clk_en,
  // Serial link pins
  input  wire logic     cs_n,
  input  wire logic     sck,
  input  wire logic     si,
  input  wire logic     pause_n,
  input  wire logic     wp_n,
  output logic          so_out,
  output logic          so_oe,
  // Command core side
  input  wire logic     busy,
  input  wire logic     core_so,
  input  wire logic     core_so_en,
  input  wire logic     wel_set,
  output logic          write_enable_latch,
  output logic          wp_active,
  output logic          cmd_abort,
  output logic          sck_rise,
  output logic          sck_fall,
  output logic          si_bit,
  output logic          asleep,
  output logic          standby,
  output logic          paused,
  output sfp_pkg::sfp_pwr_t pwr_state
);
  import sfp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Reset to idle levels: select, data, pause and protect high, clock low
  logic [4:0] pin_sync;
  sfp_sync #(.W(5)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .async_in ({cs_n, sck, si, pause_n, wp_n}),
    .rst_val  (5'h17),
    .sync_out (pin_sync)
  );
  logic cs_s, sck_s, si_s, pause_s, wp_s;
  assign cs_s    = pin_sync[4];
  assign sck_s   = pin_sync[3];
  assign si_s    = pin_sync[2];
  assign pause_s = pin_sync[1];
  assign wp_s    = pin_sync[0];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic sck_d_reg;
  logic cs_d_reg;
  logic sel;
  logic cs_rise;
  logic rise_raw;
  logic fall_raw;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end
    else if (clk_en)
    begin
      sck_d_reg <= sck_s;
      cs_d_reg  <= cs_s;
    end
  end

  assign sel      = ~cs_s;
  assign cs_rise  = cs_s & ~cs_d_reg;
  // Oversampled clock: each half period must span three system cycles
  assign rise_raw = sck_s & ~sck_d_reg;
  assign fall_raw = ~sck_s & sck_d_reg;

  // ----------------------------------------------------------------
  // Pause control
  // ----------------------------------------------------------------
  logic pause_reg;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pause_reg <= 1'b0;
    else if (clk_en)
    begin
      if (!sel)
        pause_reg <= 1'b0;
      else if (!sck_s)
        pause_reg <= ~pause_s;
    end
  end
  assign paused = pause_reg;

  assign sck_rise = rise_raw & sel & ~pause_reg & clk_en;
  assign sck_fall = fall_raw & sel & ~pause_reg & clk_en;
  assign si_bit   = si_s;
  assign wp_active = ~wp_s;

  // ----------------------------------------------------------------
  // Opcode shifter
  // ----------------------------------------------------------------
  logic [7:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] first_reg;
  logic       got_byte_reg;
  logic [7:0] shift_next;

  assign shift_next = {shift_reg[6:0], si_s};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= SFP_BIT_CNT_RST;
      first_reg    <= 8'h00;
      got_byte_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!sel)
      begin
        bit_cnt_reg  <= SFP_BIT_CNT_RST;
        if (!cs_rise)
          got_byte_reg <= 1'b0;
      end
      else if (sck_rise)
      begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7 && !got_byte_reg)
        begin
          first_reg    <= shift_next;
          got_byte_reg <= 1'b1;
        end
      end
    end
  end

  logic aligned;
  assign aligned = got_byte_reg && (bit_cnt_reg == SFP_BIT_CNT_RST);
  // Opcode match on the first byte, only at a clean deselect
  function automatic logic op_hit(
    input logic       at_edge,
    input logic [7:0] got,
    input logic [7:0] op
  );
    return at_edge && (got == op);
  endfunction

  logic req_edge;
  logic sleep_req;
  logic wake_req;
  // A deselect inside a pause aborts, so it carries no request
  assign req_edge  = cs_rise && aligned && !pause_reg;
  assign sleep_req = op_hit(req_edge, first_reg, SFP_OP_SLEEP);
  assign wake_req  = op_hit(req_edge, first_reg, SFP_OP_WAKE);

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  // Pause never gates busy or these timers, so self-timed work runs on
  sfp_pwr_t   pwr_reg;
  logic [11:0] tmr_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pwr_reg <= SFP_STANDBY;
      tmr_reg <= SFP_CNT_ZERO;
    end
    else if (clk_en)
    begin
      unique case (pwr_reg)
        SFP_STANDBY:
        begin
          if (sleep_req && !busy)
          begin
            pwr_reg <= SFP_ENTERING;
            tmr_reg <= SFP_SLEEP_ENTRY_LOAD;
          end
        end
        SFP_ENTERING:
        begin
          if (tmr_reg == SFP_CNT_ZERO)
            pwr_reg <= SFP_SLEEP;
          else
            tmr_reg <= tmr_reg - 12'h001;
        end
        SFP_SLEEP:
        begin
          if (wake_req)
          begin
            pwr_reg <= SFP_WAKING;
            tmr_reg <= SFP_SLEEP_EXIT_LOAD;
          end
        end
        SFP_WAKING:
        begin
          if (tmr_reg == SFP_CNT_ZERO)
            pwr_reg <= SFP_STANDBY;
          else
            tmr_reg <= tmr_reg - 12'h001;
        end
      endcase
    end
  end

  assign pwr_state = pwr_reg;
  assign asleep    = (pwr_reg == SFP_SLEEP);
  assign standby   = (pwr_reg == SFP_STANDBY) && !sel && !busy;

  // ----------------------------------------------------------------
  // Abort and write enable latch
  // ----------------------------------------------------------------
  // Deselect during pause
  assign cmd_abort = cs_rise & pause_reg & clk_en;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      write_enable_latch <= 1'b0;
    else if (clk_en)
    begin
      // Clear beats a same-cycle set: the aborted command must not arm writes
      // Clear latch on abort
      if (cs_rise && pause_reg)
        write_enable_latch <= 1'b0;
      else if (wel_set && pwr_reg == SFP_STANDBY)
        write_enable_latch <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Launching on the falling edge gives the host half a clock period to sample on the rising edge
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end
    else if (clk_en)
    begin
      // Float when paused, asleep or idle
      if (!sel || pause_reg || pwr_reg != SFP_STANDBY)
        so_oe <= 1'b0;
      else if (sck_fall)
      begin
        so_out <= core_so;
        so_oe  <= core_so_en;
      end
    end
  end
endmodule

// >>> core/sfp_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sfp_sync #(
  parameter int W = 4
) (
  // Clock and enable
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // Caller supplies each pin's idle level, so no false edge follows reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_reg <= rst_val;
      sync_out <= rst_val;
    end
    else if (clk_en)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// >>> tb/sfp_host.sv
// Host model driving the serial flash pins
`timescale 1ns/1ps
module sfp_host (
  // Serial pins
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic pause_n
);
  initial
  begin
    cs_n = 1'h1;
    sck = 1'h0;
    si = 1'h0;
    pause_n = 1'h1;
  end
  // MSB first, bits past the opcode sent as given
  task automatic frame(input logic [15:0] w, input int n, input int hb, input bit drop);
    cs_n = 1'h0;
    si = w[15];
    for (int i = 0; i < n; i++)
    begin
      // pause raised in the low phase, clock keeps running
      if (i == hb)
      begin
        pause_n = 1'h0;
        repeat (2)
        begin
          #160 sck = 1'h1;
          #160 sck = 1'h0;
        end
        if (drop)
        begin
          cs_n = 1'h1;
          #200 pause_n = 1'h1;
          return;
        end
        pause_n = 1'h1;
      end
      // next bit launched from the rising edge, after hold margin
      #160 sck = 1'h1;
      #120 w = w << 1;
      si = w[15];
      #40 sck = 1'h0;
    end
    #160 cs_n = 1'h1;
    // Released line shows a changed level, not the last bit
    si = ~si;
  endtask
endmodule

// >>> tb/sfp_power_hold_tb.sv
// Self-checking bench for the sleep and pause control block
`timescale 1ns/1ps
module sfp_power_hold_tb
  import sfp_pkg::*;
;
  logic sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, busy = 1'h0, core_so = 1'h0;
  logic core_so_en = 1'h1, wel_set = 1'h0, wp_n = 1'h1, m_sleep = 1'h0;
  logic cs_n, sck, si, pause_n, so_out, so_oe, write_enable_latch, wp_active;
  logic cmd_abort, sck_rise, sck_fall, si_bit, asleep, standby, paused;
  sfp_pwr_t pwr_state;
  logic [2:0] seen = 3'h0;
  logic [15:0] rx = 16'h0000;
  logic so_want = 1'h0;
  int n_rx = 0;
  int n_mismatch = 0, checked = 0, cycles = 0;
  sfp_power_hold u_dut (.*);
  sfp_host u_host (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    core_so <= 1'($urandom);
    seen <= seen | {paused === 1'h1, cmd_abort === 1'h1, so_oe === 1'h1};
    // Bits taken in, and the bit that the last falling edge should launch
    if (sck_rise === 1'h1)
    begin
      rx   <= {rx[14:0], si_bit};
      n_rx <= n_rx + 1;
    end
    if (sck_fall === 1'h1)
      so_want <= core_so;
    if (so_oe === 1'h1)
      check(so_out === so_want);
    cycles++;
    // Runs take near 4600 cycles
    if (cycles == 12000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic check(input bit ok);
    checked++;
    if (!ok)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: unexpected state", $time);
    end
  endtask
  function automatic logic exp_sleep(logic [7:0] op, int n, logic was, logic bz);
    if (n % 8 != 0)
      return was;
    if (was)
      return op != SFP_OP_WAKE;
    return op == SFP_OP_SLEEP && !bz;
  endfunction
  function automatic logic [15:0] low_bits(logic [31:0] v, int nb);
    return 16'(v & ((32'h1 << nb) - 32'h1));
  endfunction
  // Entry and exit finish within 200 cycles of deselect
  task automatic run(input logic [15:0] w, input int n, input int hb, input bit drop);
    logic e;
    int   nb;
    int   n0;
    e = drop ? m_sleep : exp_sleep(w[15:8], n, m_sleep, busy);
    nb = drop ? hb : n;
    n0 = n_rx;
    @(posedge sys_clk);
    #1 u_host.frame(w, n, hb, drop);
    repeat (220) @(posedge sys_clk);
    check(asleep === e && (busy || standby === !e));
    // Pulses inside a pause must not count; bits land first bit first
    check(n_rx - n0 == nb && low_bits(rx, nb) === low_bits(w >> (16 - nb), nb));
    m_sleep = e;
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'hC105));
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'h0;
    repeat (4) @(posedge sys_clk);
    check(pwr_state === SFP_STANDBY && standby === 1'h1);
    for (int i = 0; i < 4; i++)
    begin
      #1 wp_n = 1'($urandom);
      repeat (4) @(posedge sys_clk);
      check(wp_active === !wp_n);
    end
    run(16'hB900, 7, -1, 0);
    run(16'hB900, 12, -1, 0);
    #1 busy = 1'h1;
    run(16'hB900, 8, -1, 0);
    #1 busy = 1'h0;
    run({8'hB9, 8'($urandom)}, 16, -1, 0);
    for (int i = 0; i < 4; i++)
      run({8'($urandom), 8'h00}, 8, -1, 0);
    run(16'hAB00, 7, -1, 0);
    run(16'hAB00, 9, -1, 0);
    run({8'hAB, 8'($urandom)}, 16, -1, 0);
    run(16'hB900, 8, 3, 0);
    run(16'hAB00, 8, 5, 0);
    #1 wel_set = 1'h1;
    @(posedge sys_clk);
    #1 wel_set = 1'h0;
    repeat (2) @(posedge sys_clk);
    check(write_enable_latch === 1'h1);
    run(16'hB900, 8, 4, 1);
    check(write_enable_latch === 1'h0 && seen[2:1] === 2'h3);
    #1 core_so_en = 1'h1;
    run({8'h05, 8'($urandom)}, 16, -1, 0);
    check(seen[0] === 1'h1);
    print_verdict();
  end
endmodule

// >>> tb/sfp_props.sv
// Assertion checker for the sleep and pause control block
`timescale 1ns/1ps
module sfp_props
  import sfp_pkg::*;
(
  // Clock and pins
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cs_n,
  input wire logic        wp_n,
  input wire logic        busy,
  // Outputs watched
  input wire logic        so_out,
  input wire logic        so_oe,
  input wire logic        write_enable_latch,
  input wire logic        wp_active,
  input wire logic        cmd_abort,
  input wire logic        sck_rise,
  input wire logic        sck_fall,
  input wire logic        paused,
  input sfp_pkg::sfp_pwr_t pwr_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Longest stay in each transition state, pin latency already taken off
  sequence s_asleep;
    ##[1:72] pwr_state == SFP_SLEEP;
  endsequence
  sequence s_awake;
    ##[1:197] pwr_state == SFP_STANDBY;
  endsequence
  a_boot_standby:
    assert property ($fell(rst) |-> pwr_state == SFP_STANDBY && !paused) else $error("no standby");
  a_entry_bound:
    assert property (pwr_state == SFP_ENTERING |-> s_asleep) else $error("sleep late");
  a_exit_bound:
    assert property (pwr_state == SFP_WAKING |-> s_awake) else $error("wake late");
  a_busy_refuse:
    assert property (busy && pwr_state == SFP_STANDBY |=> pwr_state != SFP_ENTERING)
      else $error("sleep taken while busy");
  a_sleep_quiet:
    assert property ((pwr_state != SFP_STANDBY) [*2] |-> !so_oe) else $error("so driven");
  a_pause_float:
    assert property (paused [*2] |-> !so_oe && !sck_rise && !sck_fall)
      else $error("pause not quiet");
  a_pause_sel:
    assert property (cs_n [*8] |-> !paused) else $error("paused while deselected");
  a_abort_wel:
    assert property (cmd_abort |-> ##[0:1] !write_enable_latch) else $error("latch kept");
  a_so_launch:
    assert property (so_oe && $past(so_oe) && $changed(so_out) |-> $past(sck_fall))
      else $error("so changed off falling edge");
  a_wp_live:
    assert property (!wp_n [*4] |-> wp_active) else $error("write protect lost");
endmodule
bind sfp_power_hold sfp_props u_props (
  .sys_clk            (sys_clk),
  .rst                (rst),
  .cs_n               (cs_n),
  .wp_n               (wp_n),
  .busy               (busy),
  .so_out             (so_out),
  .so_oe              (so_oe),
  .write_enable_latch (write_enable_latch),
  .wp_active          (wp_active),
  .cmd_abort          (cmd_abort),
  .sck_rise           (sck_rise),
  .sck_fall           (sck_fall),
  .paused             (paused),
  .pwr_state          (pwr_state)
);
